// [hw/limit_value_output_control.sv]
`timescale 1ns/1ps
`include "limit_ctrl_cfg.svh"
`default_nettype none

module limit_value_output_control #(
    parameter int unsigned ALARM_PULSE_CYC = `ALARM_PULSE_CYC,
    parameter int unsigned FLASH_CYC       = 50000000
) (
    // Clock and reset
    input  wire logic                             clk_i,
    input  wire logic                             rst_n_i,
    // Analysis results
    input  wire logic                             result_valid_i,
    input  wire logic [15:0]                      result_i,
    input  wire logic                             ext_start_i,
    input  wire logic                             standby_key_i,
    // Limit configuration
    input  wire limit_ctrl_pkg::limit_cfg_t [1:0] limit_cfg_i,
    // Plant control
    input  wire logic                             regeneration_input_i,
    input  wire logic                             regen_nc_i,
    input  wire logic                             water_meter_input_i,
    input  wire logic [31:0]                      good_quantity_i,
    input  wire logic                             plant_reset_i,
    // Reserve monitoring
    input  wire logic                             reserve_monitoring_i,
    input  wire logic                             volume_mode_i,
    input  wire logic [7:0]                       reserve_hours_i,
    input  wire logic [31:0]                      reagent_left_i,
    input  wire logic [31:0]                      use_per_hour_i,
    input  wire logic [7:0]                       fill_pct_i,
    // Fault events
    input  wire logic [`EVT_COUNT-1:0]            event_i,
    input  wire logic [`EVT_COUNT*2-1:0]          event_action_i,
    // Outputs
    output logic [1:0]                            func_reject_o,
    output limit_ctrl_pkg::limit_out_t [1:0]      limit_out_o,
    output logic                                  start_now_o,
    output logic                                  analysis_start_o,
    output logic                                  standby_o,
    output logic                                  hold_sample_o,
    output logic                                  reserve_flash_o,
    output logic                                  maint_lamp_o,
    output logic                                  maint_out_o,
    output logic                                  alarm_relay_o
);

    // ************************************************************
    // Exceed detection and hysteresis
    // ************************************************************
    logic [1:0] exceed;
    logic [1:0] below;
    logic [1:0] cnt_q [2];
    logic [1:0] switched_q;
    logic [1:0] sw_prev_q;
    logic [1:0] sw_rise;
    logic [1:0] armed_q;
    logic [1:0] first_q;
    logic [1:0] effective_func [2];
    logic       lock_q;

    // Two-point only on output one without lock-out; strict compare
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            effective_func[i] = limit_cfg_i[i].func;
            func_reject_o[i]  = 1'b0;
            if (limit_cfg_i[i].func == `FUNC_TWO_POINT &&
                (i == 1 || limit_cfg_i[i].lockout)) begin
                effective_func[i] = `FUNC_DURATION;
                func_reject_o[i]  = 1'b1;
            end
            exceed[i] = result_valid_i &&
                        result_i > limit_cfg_i[i].limit;
            below[i]  = result_valid_i && !exceed[i];
        end
    end

    // Consecutive exceed counter per output
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            cnt_q[0]   <= 2'd0;
            cnt_q[1]   <= 2'd0;
            switched_q <= 2'b00;
            sw_prev_q  <= 2'b00;
            armed_q    <= 2'b11;
            first_q    <= 2'b00;
        end else begin
            sw_prev_q <= switched_q;
            for (int i = 0; i < 2; i++) begin
                logic [1:0] hyst;
                hyst = (limit_cfg_i[i].hyst == 2'd0) ?
                       `HYST_DEFAULT : limit_cfg_i[i].hyst;
                first_q[i] <= 1'b0;
                if (below[i]) begin
                    cnt_q[i]      <= 2'd0;
                    switched_q[i] <= 1'b0;
                    armed_q[i]    <= 1'b1;
                end else if (exceed[i] && armed_q[i]) begin
                    if (cnt_q[i] + 2'd1 >= hyst) begin
                        switched_q[i] <= 1'b1;
                        armed_q[i]    <= 1'b0;
                        cnt_q[i]      <= 2'd0;
                    end else begin
                        cnt_q[i]   <= cnt_q[i] + 2'd1;
                        first_q[i] <= (cnt_q[i] == 2'd0);
                    end
                end
            end
        end
    end

    // Quick re-analysis; switch events, as a level would relock at once
    assign start_now_o = |first_q;
    assign sw_rise     = switched_q & ~sw_prev_q;

    // ************************************************************
    // Lock-out and standby
    // ************************************************************
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            lock_q <= 1'b0;
        end else if (lock_q && standby_key_i) begin
            lock_q <= 1'b0;
        end else if ((sw_rise[0] && limit_cfg_i[0].lockout) ||
                     (sw_rise[1] && limit_cfg_i[1].lockout)) begin
            lock_q <= 1'b1;
        end
    end

    // Standby blocks the external start path
    assign standby_o        = lock_q;
    assign hold_sample_o    = lock_q;
    assign analysis_start_o = ext_start_i && !lock_q;

    // ************************************************************
    // Relay switch functions
    // ************************************************************
    logic [1:0]  relay_q;
    logic [31:0] tmr_q [2];

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            relay_q  <= 2'b00;
            tmr_q[0] <= 32'h0;
            tmr_q[1] <= 32'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                logic hold;
                // Lock-out keeps duration and interval relays going until key release; impulse relays still time out
                hold = limit_cfg_i[i].lockout && lock_q;
                unique case (effective_func[i])
                    `FUNC_DURATION: begin
                        relay_q[i] <= switched_q[i] ||
                                      (hold && relay_q[i]);
                    end
                    `FUNC_IMPULSE: begin
                        if (sw_rise[i]) begin
                            relay_q[i] <= 1'b1;
                            tmr_q[i]   <= limit_cfg_i[i].relay_time;
                        end else if (relay_q[i]) begin
                            if (tmr_q[i] <= 32'h1) begin
                                relay_q[i] <= 1'b0;
                                tmr_q[i]   <= 32'h0;
                            end else begin
                                tmr_q[i] <= tmr_q[i] - 32'h1;
                            end
                        end
                    end
                    `FUNC_INTERVAL: begin
                        if (switched_q[i] || hold) begin
                            if (tmr_q[i] <= 32'h1) begin
                                relay_q[i] <= !relay_q[i];
                                tmr_q[i]   <= limit_cfg_i[i].relay_time;
                            end else begin
                                tmr_q[i] <= tmr_q[i] - 32'h1;
                            end
                        end else begin
                            relay_q[i] <= 1'b0;
                            tmr_q[i]   <= 32'h0;
                        end
                    end
                    `FUNC_TWO_POINT: begin
                        if (exceed[0]) begin
                            relay_q[i] <= 1'b1;
                        end else if (result_valid_i &&
                                     result_i < limit_cfg_i[1].limit) begin
                                     relay_q[i] <= 1'b0;
                        end
                    end
                endcase
            end
        end
    end

    // Lamps follow the switched state
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            limit_out_o[i].relay = relay_q[i];
            limit_out_o[i].red   = switched_q[i];
            limit_out_o[i].green = !switched_q[i];
        end
    end

    // ************************************************************
    // Plant control
    // ************************************************************
    logic        regen_act;
    logic        regen_q;
    logic        meter_q;
    logic [31:0] water_q;
    logic        plant_evt_q;

    assign regen_act = regeneration_input_i ^ regen_nc_i;

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            regen_q     <= 1'b0;
            meter_q     <= 1'b0;
            water_q     <= 32'h0;
            plant_evt_q <= 1'b0;
        end else begin
            regen_q     <= regen_act;
            meter_q     <= water_meter_input_i;
            plant_evt_q <= 1'b0;
            if (|exceed) begin
                if (good_quantity_i != 32'h0 &&
                    water_q < good_quantity_i) begin
                    plant_evt_q <= 1'b1;
                end
                water_q <= 32'h0;
            end else if ((regen_act && !regen_q) || plant_reset_i) begin
                water_q <= 32'h0;
            end else if (water_meter_input_i && !meter_q) begin
                water_q <= water_q + 32'h1;
            end
        end
    end

    // ************************************************************
    // Reserve monitoring
    // ************************************************************
    logic        reserve_on;
    logic        shortfall;
    logic [39:0] need;
    logic [31:0] flash_q;
    logic        flash_ph_q;

    assign reserve_on = reserve_monitoring_i && !volume_mode_i;
    assign need = 40'(use_per_hour_i) * 40'(reserve_hours_i);
    assign shortfall = reserve_on ? (40'(reagent_left_i) < need)
                                  : (fill_pct_i < `RESERVE_MIN_PCT);

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            flash_q    <= 32'h0;
            flash_ph_q <= 1'b0;
        end else if (flash_q >= FLASH_CYC - 1) begin
            flash_q    <= 32'h0;
            flash_ph_q <= !flash_ph_q;
        end else begin
            flash_q <= flash_q + 32'h1;
        end
    end

    assign reserve_flash_o = reserve_on && shortfall && flash_ph_q;
    assign maint_lamp_o    = reserve_on && shortfall;
    assign maint_out_o     = reserve_on && shortfall;

    // ************************************************************
    // Alarm relay
    // ************************************************************
    logic [`EVT_COUNT-1:0] evt;
    logic [`EVT_COUNT-1:0] evt_q;
    logic                  alarm_hold;
    logic                  msg_start;
    logic [31:0]           pulse_q;

    always_comb begin
        evt = event_i;
        evt[`EVT_REAGENT_LOW]   = event_i[`EVT_REAGENT_LOW] || shortfall;
        evt[`EVT_PLANT_CONTROL] = plant_evt_q;
        alarm_hold = 1'b0;
        msg_start  = 1'b0;
        for (int e = 0; e < `EVT_COUNT; e++) begin
            if (event_action_i[2*e +: 2] == 2'(limit_ctrl_pkg::ACT_ALARM)) begin
                alarm_hold = alarm_hold || evt[e];
            end else if (event_action_i[2*e +: 2] ==
                         2'(limit_ctrl_pkg::ACT_MESSAGE)) begin
                msg_start = msg_start || (evt[e] && !evt_q[e]);
            end
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            evt_q   <= '0;
            pulse_q <= 32'h0;
        end else begin
            evt_q <= evt;
            if (msg_start) begin
                pulse_q <= ALARM_PULSE_CYC;
            end else if (pulse_q != 32'h0) begin
                pulse_q <= pulse_q - 32'h1;
            end
        end
    end

    assign alarm_relay_o = alarm_hold || (pulse_q != 32'h0);

    // ************************************************************
    // Checks
    // ************************************************************
    a_lock_blocks_start: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) lock_q |-> !analysis_start_o)
        else $error("start passed while locked");
    a_green_red_excl: assert property (@(posedge clk_i)
        disable iff (!rst_n_i)
        limit_out_o[0].red != limit_out_o[0].green)
        else $error("lamp state inconsistent");
    a_below_rearms: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) below[0] |=> armed_q[0] && !switched_q[0])
        else $error("no rearm after below");
    a_key_releases: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) lock_q && standby_key_i |=> !lock_q)
        else $error("standby key ignored");
    a_two_point_reject: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) limit_cfg_i[0].lockout &&
        limit_cfg_i[0].func == `FUNC_TWO_POINT |-> func_reject_o[0])
        else $error("two-point accepted with lock-out");
    a_msg_pulse: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) msg_start |=> alarm_relay_o [*8])
        else $error("message pulse too short");
    a_plant_zero: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) good_quantity_i == 32'h0 |=> !plant_evt_q)
        else $error("plant event with zero quantity");
    a_volume_no_res: assert property (@(posedge clk_i)
        disable iff (!rst_n_i) volume_mode_i |-> !maint_out_o)
        else $error("reserve active in volume mode");

endmodule : limit_value_output_control

`default_nettype wire

// [hw/limit_ctrl_cfg.svh]
`ifndef LIMIT_CTRL_CFG_SVH
`define LIMIT_CTRL_CFG_SVH
`define CLK_PERIOD_NS      10
`define ALARM_PULSE_MS     2000
`define ALARM_PULSE_CYC    ((`ALARM_PULSE_MS * 1000000) / `CLK_PERIOD_NS)
`define HYST_DEFAULT       2'd1
`define FUNC_DURATION      2'd0
`define FUNC_IMPULSE       2'd1
`define FUNC_INTERVAL      2'd2
`define FUNC_TWO_POINT     2'd3
`define EVT_COUNT          14
`define EVT_REAGENT_LOW    0
`define EVT_PLANT_CONTROL  10
`define RESERVE_MIN_PCT    8'd10
`define RESERVE_H_MIN      8'd24
`define RESERVE_H_MAX      8'd120
`endif

// [hw/limit_ctrl_pkg.sv]
package limit_ctrl_pkg;
    // Action taken by an event on the alarm relay
    typedef enum logic [1:0] {
        ACT_NONE,
        ACT_ALARM,
        ACT_MESSAGE
    } event_action_t;

    // Per limit output settings
    typedef struct packed {
        logic [15:0] limit;
        logic [1:0]  hyst;
        logic [1:0]  func;
        logic        lockout;
        logic [31:0] relay_time;
    } limit_cfg_t;

    // Per limit output indicators
    typedef struct packed {
        logic relay;
        logic red;
        logic green;
    } limit_out_t;
endpackage : limit_ctrl_pkg

// [bench/plant_partner.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Plant controller and water meter model
// ****************************************
module plant_partner (
    // Clock
    input  wire logic clk_i,
    // Requests from the bench
    input  wire logic regen_req_i,
    input  wire logic nc_i,
    input  wire logic meter_req_i,
    // Contact lines
    output logic      regen_line_o,
    output logic      meter_line_o
);
    // A normally closed contact opens while regeneration runs
    assign regen_line_o = nc_i ? !regen_req_i : regen_req_i;
    // One meter unit: contact closed two cycles, then open again
    initial meter_line_o = 1'b0;
    always @(posedge clk_i) begin
        if (meter_req_i && !meter_line_o) begin
            meter_line_o <= 1'b1;
            repeat (2) @(posedge clk_i);
            meter_line_o <= 1'b0;
        end
    end
endmodule : plant_partner
`default_nettype wire

// [bench/testbench.sv]
`timescale 1ns/1ps
`default_nettype none
module testbench;
    typedef struct {string nm; int idx; logic exp;} note_t;
    logic clk, rst_n, vld, ext, key, rreq, nc, mreq, preset, res_on, vol;
    logic regen_line, meter_line;
    logic [15:0] rslt, lim;
    logic [31:0] good, left, use_h, seed;
    logic [7:0]  hrs, fill;
    logic [13:0] evt;
    logic [27:0] act;
    logic [1:0]  rej;
    logic        r1p;
    logic        rfp;
    logic [16:0] obs;
    limit_ctrl_pkg::limit_cfg_t [1:0] cfg;
    limit_ctrl_pkg::limit_out_t [1:0] lo;
    logic sn, ana, stb, hold, mlamp, mout, alrm, rfl;
    int mismatches, total_checks, sn_cnt, sb, rc, rb, fc, fb;
    note_t q[$];
    note_t n;
    // ******************
    // Design and partner
    // ******************
    limit_value_output_control #(.ALARM_PULSE_CYC(16), .FLASH_CYC(4)) dut (
        .clk_i(clk), .rst_n_i(rst_n), .result_valid_i(vld), .result_i(rslt),
        .ext_start_i(ext), .standby_key_i(key), .limit_cfg_i(cfg),
        .regeneration_input_i(regen_line), .regen_nc_i(nc),
        .water_meter_input_i(meter_line), .good_quantity_i(good),
        .plant_reset_i(preset), .reserve_monitoring_i(res_on),
        .volume_mode_i(vol), .reserve_hours_i(hrs), .reagent_left_i(left),
        .use_per_hour_i(use_h), .fill_pct_i(fill), .event_i(evt),
        .event_action_i(act), .func_reject_o(rej), .limit_out_o(lo),
        .start_now_o(sn), .analysis_start_o(ana), .standby_o(stb),
        .hold_sample_o(hold), .reserve_flash_o(rfl), .maint_lamp_o(mlamp),
        .maint_out_o(mout), .alarm_relay_o(alrm));
    plant_partner partner (.clk_i(clk), .regen_req_i(rreq), .nc_i(nc),
        .meter_req_i(mreq), .regen_line_o(regen_line),
        .meter_line_o(meter_line));
    // Observed outputs; three bench-derived flags on top
    assign obs = {(fc - fb) >= 3, (sn_cnt - sb) == 1, (rc - rb) >= 3,
        mlamp, rej, alrm, mout, ana, hold, stb, lo[1].relay, lo[1].red,
        lo[1].green, lo[0].relay, lo[0].red, lo[0].green};
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    // Pulse and edge counters, kept apart from the watcher
    always @(posedge clk) begin
        if (sn === 1'b1) sn_cnt++;
        if (lo[1].relay === 1'b1 && r1p !== 1'b1) rc++;
        r1p = lo[1].relay;
        if (rfl === 1'b1 && rfp !== 1'b1) fc++;
        rfp = rfl;
    end
    // Watcher: waits past the falling edge so notes of that edge are queued
    initial begin
        forever begin
            @(negedge clk);
            #1;
            while (q.size() > 0) begin
                n = q.pop_front();
                total_checks++;
                if (obs[n.idx] !== n.exp) begin
                    mismatches++;
                    $display("BAD %s expected %b seen %b", n.nm, n.exp,
                        obs[n.idx]);
                end
            end
        end
    end
    task automatic chk(input string nm, input int idx, input logic e);
        q.push_back('{nm, idx, e});
    endtask : chk
    task automatic tick(input int k);
        repeat (k) @(negedge clk);
    endtask : tick
    task automatic res(input logic [15:0] v);
        @(negedge clk);
        rslt = v;
        vld = 1'b1;
        @(negedge clk);
        vld = 1'b0;
        tick(3);
    endtask : res
    task automatic do_rst;
        tick(1);
        rst_n = 1'b0;
        tick(2);
        rst_n = 1'b1;
        tick(1);
    endtask : do_rst
    task automatic meter(input int k);
        repeat (k) begin
            mreq = 1'b1;
            tick(1);
            mreq = 1'b0;
            tick(4);
        end
    endtask : meter
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : end_of_test
    // Watchdog sized well above the whole sequence
    initial begin
        repeat (20000) @(posedge clk);
        mismatches++;
        end_of_test();
    end
    // ******************
    // Main sequence
    // ******************
    initial begin
        seed = 32'hbe844ca7;
        {rst_n, vld, ext, key, rreq, nc, mreq, preset, res_on, vol} = '0;
        {rslt, good, left, use_h, hrs, fill, evt} = '0;
        act = '0;
        act[1:0] = 2'b01;
        act[21:20] = 2'b10;
        fill = 8'h32;
        lim = 16'h0064 + 16'($unsigned($random(seed)) % 1000);
        cfg[0] = '{lim, 2'h2, 2'h0, 1'b0, 32'h4};
        cfg[1] = '{16'hffff, 2'h1, 2'h0, 1'b0, 32'h4};
        do_rst();
        chk("green0", 0, 1'b1);
        chk("relay0", 2, 1'b0);
        sb = sn_cnt;
        res(lim + 16'h1);
        chk("start_now", 15, 1'b1);
        chk("red0", 1, 1'b0);
        res(lim + 16'h1);
        chk("red0", 1, 1'b1);
        chk("relay0", 2, 1'b1);
        res(lim);
        chk("relay0", 2, 1'b0);
        chk("green0", 0, 1'b1);
        res(lim + 16'h1);
        chk("red0", 1, 1'b0);
        // Three bad analyses needed before switching
        cfg[0].hyst = 2'h3;
        do_rst();
        res(lim + 16'h1);
        res(lim + 16'h2);
        chk("red0", 1, 1'b0);
        res(lim + 16'h3);
        chk("red0", 1, 1'b1);
        // Impulse on output two: one pulse per excursion
        cfg[0].limit = 16'hffff;
        cfg[1] = '{lim, 2'h1, 2'h1, 1'b0, 32'h6};
        do_rst();
        res(lim + 16'h1);
        chk("relay1", 5, 1'b1);
        repeat (3) res(lim + 16'h5);
        chk("relay1", 5, 1'b0);
        res(lim);
        res(lim + 16'h1);
        chk("relay1", 5, 1'b1);
        // Interval: relay keeps toggling while exceeded
        cfg[1].func = 2'h2;
        cfg[1].relay_time = 32'h3;
        do_rst();
        rb = rc;
        res(lim + 16'h1);
        tick(30);
        chk("toggles", 14, 1'b1);
        // Two-point between the two limits
        cfg[0] = '{lim + 16'h64, 2'h1, 2'h3, 1'b0, 32'h4};
        cfg[1] = '{lim, 2'h1, 2'h0, 1'b0, 32'h4};
        do_rst();
        chk("reject0", 11, 1'b0);
        res(lim + 16'h65);
        res(lim + 16'h32);
        chk("relay0", 2, 1'b1);
        chk("relay1", 5, 1'b1);
        res(lim - 16'h1);
        chk("relay0", 2, 1'b0);
        cfg[0].lockout = 1'b1;
        cfg[1].func = 2'h3;
        tick(2);
        chk("reject0", 11, 1'b1);
        chk("reject1", 12, 1'b1);
        tick(1);
        // Lock-out into standby
        cfg[0] = '{lim, 2'h1, 2'h0, 1'b1, 32'h4};
        cfg[1].limit = 16'hffff;
        cfg[1].func = 2'h0;
        ext = 1'b1;
        do_rst();
        chk("ana_start", 8, 1'b1);
        res(lim + 16'h1);
        chk("standby", 6, 1'b1);
        chk("hold", 7, 1'b1);
        chk("ana_start", 8, 1'b0);
        res(lim);
        chk("relay0", 2, 1'b1);
        key = 1'b1;
        tick(1);
        key = 1'b0;
        tick(2);
        chk("standby", 6, 1'b0);
        chk("ana_start", 8, 1'b1);
        // Plant control with a good quantity of five units
        cfg[0].lockout = 1'b0;
        good = 32'h5;
        do_rst();
        res(lim + 16'h1);
        tick(25);
        res(lim);
        meter(2);
        res(lim + 16'h1);
        chk("alarm", 10, 1'b1);
        tick(25);
        chk("alarm", 10, 1'b0);
        res(lim);
        meter(7);
        res(lim + 16'h1);
        chk("alarm", 10, 1'b0);
        // Count cleared by regeneration either polarity, or by hand
        for (int p = 0; p < 3; p++) begin
            nc = (p == 1);
            tick(25);
            res(lim);
            meter(7);
            if (p < 2) rreq = 1'b1;
            else preset = 1'b1;
            tick(2);
            {rreq, preset} = 2'b00;
            tick(2);
            res(lim + 16'h1);
            chk("alarm", 10, 1'b1);
        end
        good = 32'h0;
        tick(25);
        res(lim);
        res(lim + 16'h1);
        chk("alarm", 10, 1'b0);
        tick(1);
        fb = fc;
        // Reserve: 2 per hour for 72 h needs 144, only 100 left
        {res_on, hrs, use_h, left} = {1'b1, 8'h48, 32'h2, 32'h64};
        tick(3);
        chk("maint_out", 9, 1'b1);
        chk("maint_lamp", 13, 1'b1);
        tick(40);
        chk("alarm", 10, 1'b1);
        chk("flash", 16, 1'b1);
        tick(1);
        vol = 1'b1;
        tick(3);
        chk("maint_out", 9, 1'b0);
        {vol, left} = {1'b0, 32'h3e8};
        tick(3);
        chk("maint_out", 9, 1'b0);
        {res_on, left, fill} = {1'b0, 32'h64, 8'h09};
        tick(3);
        chk("alarm", 10, 1'b1);
        tick(1);
        fill = 8'h32;
        tick(25);
        chk("alarm", 10, 1'b0);
        // A fault set to no action stays silent, then as alarm
        evt[3] = 1'b1;
        tick(3);
        chk("alarm", 10, 1'b0);
        tick(1);
        act[7:6] = 2'b01;
        tick(3);
        chk("alarm", 10, 1'b1);
        tick(2);
        end_of_test();
    end
endmodule : testbench
`default_nettype wire
